// ---- pkg/asr_pkg.sv ----
// Shared constants and types for the static memory host controller
package asr_pkg;

    // Memory organisation
    localparam int INDEX_W = 13;
    localparam int DATA_W  = 9;

    // System clock period
    localparam int CLK_PERIOD_NS = 20;

    // Slowest speed grade figures, so any grade of part is served
    localparam int T_RC_NS  = 35;   // Read cycle time
    localparam int T_AA_NS  = 35;   // Index access time
    localparam int T_HZ_NS  = 20;   // Select removal to float
    localparam int T_OHZ_NS = 15;   // Output gate rise to float
    localparam int T_AW_NS  = 30;   // Index valid to end of write
    localparam int T_WP_NS  = 25;   // Write strobe width
    localparam int T_DW_NS  = 15;   // Data setup to end of write

    // Synchroniser depth on returning data pins
    localparam int SYNC_STAGES = 2;

    // Least times rounded up to whole cycles, never under one
    localparam int RD_ACC_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC_A   = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC_B   = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC  = (HZ_CYC_A > HZ_CYC_B) ? HZ_CYC_A : HZ_CYC_B;
    localparam int WP_CYC     = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DW_CYC     = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AW_CYC     = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPD_CYC    = (WP_CYC > DW_CYC) ? WP_CYC : DW_CYC;
    localparam int PULSE_CYC  = (WPD_CYC > AW_CYC - 1) ? WPD_CYC : AW_CYC - 1;
    localparam int RC_CYC     = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter load values, one less than the number of cycles spent
    localparam logic [2:0] RD_WAIT_LD  = 3'(RD_ACC_CYC + SYNC_STAGES - 1);
    localparam logic [2:0] FLOAT_LD    = 3'(FLOAT_CYC - 1);
    localparam logic [2:0] WR_PULSE_LD = 3'(PULSE_CYC - 1);
    localparam logic [2:0] WAKE_LD     = 3'(RC_CYC - 1);
    localparam logic [2:0] CNT_ZERO    = 3'h0;

    // Reset values of pin drivers
    localparam logic [INDEX_W-1:0] INDEX_RST = 13'h0000;
    localparam logic [DATA_W-1:0]  DATA_RST  = 9'h000;

    // Controller states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_FLOAT,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_SLEEP,
        ST_WAKE
    } asr_state_t;

endpackage

// ---- logic/asr_sync.sv ----
// Two-stage synchroniser for a bus of asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module asr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // First stage feeds only the second stage
    logic [WIDTH-1:0] meta_reg;

    // Two flops per bit; metastability settles in the first
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ---- logic/asr_host_ctrl.sv ----
// Host controller driving an asynchronous 8K by 9 static memory
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Space cycles by at least cycle time
// - Index and selects lead write end
// - Write data setup before end, hold after
// - Index stable around write, zero setup/recovery
// - Never fight memory driving the data pins
// - Deselect before retention, wait after recovery
module asr_host_ctrl
    import asr_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_write,
    input  wire logic [INDEX_W-1:0] req_index,
    input  wire logic [DATA_W-1:0]  req_wdata,
    output logic                    rsp_valid,
    output logic      [DATA_W-1:0]  rsp_rdata,
    input  wire logic               sleep_req,
    output logic                    sleep_ack,
    output logic      [INDEX_W-1:0] word_index,
    output logic                    select_low_n,
    output logic                    select_high,
    output logic                    output_gate_n,
    output logic                    write_strobe_n,
    input  wire logic [DATA_W-1:0]  data_in,
    output logic      [DATA_W-1:0]  data_out,
    output logic                    data_oe
);

    // Sequencer state and its wait counter
    asr_state_t         state_reg;
    asr_state_t         state_next;
    logic [2:0]         cnt_reg;
    logic [2:0]         cnt_next;

    // Pin driver registers
    logic [INDEX_W-1:0] index_reg;
    logic [INDEX_W-1:0] index_next;
    logic [DATA_W-1:0]  wdata_reg;
    logic [DATA_W-1:0]  wdata_next;
    logic               sel_reg;       // Both selects active when set
    logic               sel_next;
    logic               gate_reg;      // Output gate active when set
    logic               gate_next;
    logic               strobe_reg;    // Write strobe active when set
    logic               strobe_next;
    logic               doe_reg;       // Host drives data pins when set
    logic               doe_next;

    // Answer registers
    logic [DATA_W-1:0]  rdata_reg;
    logic [DATA_W-1:0]  rdata_next;
    logic               rsp_reg;
    logic               rsp_next;
    logic               ack_reg;
    logic               ack_next;

    // Data pins after the synchroniser
    logic [DATA_W-1:0]  data_sync;

    // Decoded conditions
    wire                idle_w     = (state_reg == ST_IDLE);
    wire                cnt_done_w = (cnt_reg == CNT_ZERO);
    wire                take_w     = idle_w && req_valid && !sleep_req;
    wire                take_rd_w  = take_w && !req_write;
    wire                take_wr_w  = take_w && req_write;
    wire                enter_slp  = idle_w && sleep_req;

    // Pins arrive from outside the clock domain
    asr_sync #(
        .WIDTH    (DATA_W)
    ) u_data_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in (data_in),
        .sync_out (data_sync)
    );

    // Ready only while idle; sleep holds requests off
    assign req_ready = idle_w && !sleep_req;

    // Next-state and pin sequencing
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        index_next  = index_reg;
        wdata_next  = wdata_reg;
        sel_next    = sel_reg;
        gate_next   = gate_reg;
        strobe_next = strobe_reg;
        doe_next    = doe_reg;
        rdata_next  = rdata_reg;
        rsp_next    = 1'b0;
        ack_next    = ack_reg;
        case (state_reg)
            ST_IDLE: begin
                // Parked: deselected, strobes high, bus released
                if (take_rd_w) begin
                    // Index, selects and gate together; host stays off bus
                    index_next = req_index;
                    sel_next   = 1'b1;
                    gate_next  = 1'b1;
                    doe_next   = 1'b0;
                    cnt_next   = RD_WAIT_LD;
                    state_next = ST_RD_WAIT;
                end else if (take_wr_w) begin
                    // Gate kept high so the memory never drives back
                    index_next = req_index;
                    wdata_next = req_wdata;
                    sel_next   = 1'b1;
                    gate_next  = 1'b0;
                    doe_next   = 1'b1;
                    state_next = ST_WR_SETUP;
                end else if (enter_slp) begin
                    // Already deselected, so retention may start now
                    ack_next   = 1'b1;
                    state_next = ST_SLEEP;
                end
            end
            ST_RD_WAIT: begin
                // Access time plus synchroniser latency before sampling
                if (cnt_done_w) begin
                    rdata_next = data_sync;
                    rsp_next   = 1'b1;
                    sel_next   = 1'b0;
                    gate_next  = 1'b0;
                    cnt_next   = FLOAT_LD;
                    state_next = ST_RD_FLOAT;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_RD_FLOAT: begin
                // Let the memory float before anyone drives the bus
                if (cnt_done_w) begin
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_WR_SETUP: begin
                // One cycle of index and data setup ahead of the strobe
                strobe_next = 1'b1;
                cnt_next    = WR_PULSE_LD;
                state_next  = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                // Strobe width and data setup both counted here
                if (cnt_done_w) begin
                    strobe_next = 1'b0;
                    state_next  = ST_WR_HOLD;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_WR_HOLD: begin
                // Index and data held a cycle past the strobe rise
                sel_next   = 1'b0;
                doe_next   = 1'b0;
                state_next = ST_IDLE;
            end
            ST_SLEEP: begin
                // Stay deselected until the supply is back
                if (!sleep_req) begin
                    ack_next   = 1'b0;
                    cnt_next   = WAKE_LD;
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Recovery of one read cycle before next access
                if (cnt_done_w) begin
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            default: begin
                // Unknown state: park safely
                sel_next    = 1'b0;
                gate_next   = 1'b0;
                strobe_next = 1'b0;
                doe_next    = 1'b0;
                ack_next    = 1'b0;
                state_next  = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Pin driver registers; reset leaves the memory deselected
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            index_reg  <= INDEX_RST;
            wdata_reg  <= DATA_RST;
            sel_reg    <= 1'b0;
            gate_reg   <= 1'b0;
            strobe_reg <= 1'b0;
            doe_reg    <= 1'b0;
        end else begin
            index_reg  <= index_next;
            wdata_reg  <= wdata_next;
            sel_reg    <= sel_next;
            gate_reg   <= gate_next;
            strobe_reg <= strobe_next;
            doe_reg    <= doe_next;
        end
    end

    // Answer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= DATA_RST;
            rsp_reg   <= 1'b0;
            ack_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
            ack_reg   <= ack_next;
        end
    end

    // Pins in their electrical sense; both selects move as one
    assign word_index     = index_reg;
    assign select_low_n   = !sel_reg;
    assign select_high    = sel_reg;
    assign output_gate_n  = !gate_reg;
    assign write_strobe_n = !strobe_reg;
    assign data_out       = wdata_reg;
    assign data_oe        = doe_reg;
    assign rsp_valid      = rsp_reg;
    assign rsp_rdata      = rdata_reg;
    assign sleep_ack      = ack_reg;

endmodule
`default_nettype wire

// ---- dv/asr_sram_model.sv ----
// Behavioural model of the clockless 8K by 9 static memory
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
(
    input  wire logic [INDEX_W-1:0] word_index,
    input  wire logic               select_low_n,
    input  wire logic               select_high,
    input  wire logic               output_gate_n,
    input  wire logic               write_strobe_n,
    input  wire logic [DATA_W-1:0]  host_data,
    input  wire logic               host_oe,
    input  wire logic               slow,
    output logic      [DATA_W-1:0]  pin_level,
    output logic                    clash
);
    logic [DATA_W-1:0] mem [0:8191];   // Word store, kept while powered
    logic [DATA_W-1:0] last_v = 9'h000; // Last driven level
    logic [DATA_W-1:0] drv_v;           // Level of whoever drives
    logic              sel;             // Both selects active
    logic              drive;           // Read mode by truth table
    logic              drive_d = 1'b0;  // Drive after pin delays
    logic              driven;
    assign sel   = !select_low_n && select_high;
    assign drive = sel && !output_gate_n && write_strobe_n;
    // Slow part turns on at the full access time but floats within the gate limit;
    // a float slower than the limit would fake a fight the controller never causes
    always @(drive) begin
        if (slow) begin
            drive_d <= #(drive ? 35 : 15) drive;
        end else begin
            drive_d <= #8 drive;
        end
    end
    // Word is taken as the strobe ends under select
    always @(posedge write_strobe_n) begin
        if (sel) begin
            mem[word_index] = pin_level;
        end
    end
    assign driven = drive_d || host_oe;
    assign drv_v  = drive_d ? mem[word_index] : host_data;
    assign clash  = drive_d && host_oe;
    // Remember level so a floating bus shows its inverse, not a lucky match
    always @(drv_v or driven) begin
        if (driven) begin
            last_v = drv_v;
        end
    end
    assign pin_level = driven ? drv_v : ~last_v;
endmodule
`default_nettype wire

// ---- dv/asr_host_ctrl_sva.sv ----
// Port checker for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module asr_host_ctrl_chk
    import asr_pkg::*;
(
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input wire logic               req_valid,
    input wire logic               req_ready,
    input wire logic               req_write,
    input wire logic [INDEX_W-1:0] req_index,
    input wire logic [DATA_W-1:0]  req_wdata,
    input wire logic               rsp_valid,
    input wire logic               sleep_ack,
    input wire logic [INDEX_W-1:0] word_index,
    input wire logic               select_low_n,
    input wire logic               select_high,
    input wire logic               output_gate_n,
    input wire logic               write_strobe_n,
    input wire logic [DATA_W-1:0]  data_out,
    input wire logic               data_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic tk_rd; // Read taken
    logic tk_wr; // Write taken
    assign tk_rd = req_valid && req_ready && !req_write;
    assign tk_wr = req_valid && req_ready && req_write;
    a_selects_paired: assert property (select_high == !select_low_n)
        else $error("selects disagree");
    a_read_pins: assert property (tk_rd |=> !select_low_n && !output_gate_n
        && write_strobe_n && word_index == $past(req_index)) else $error("read pins wrong");
    a_read_answer: assert property (tk_rd |=> !rsp_valid[*4] ##1 rsp_valid ##1 !rsp_valid)
        else $error("read answer late or early");
    a_write_walk: assert property (tk_wr |=> data_oe && output_gate_n && write_strobe_n
        ##1 !write_strobe_n[*2] ##1 write_strobe_n ##1 !data_oe && select_low_n)
        else $error("write sequence wrong");
    a_write_data: assert property (tk_wr |=> data_out == $past(req_wdata)
        && word_index == $past(req_index)) else $error("write data wrong");
    a_strobe_qual: assert property (!write_strobe_n |-> !select_low_n && data_oe)
        else $error("strobe unqualified");
    a_hold_stable: assert property (!write_strobe_n |-> $stable(word_index)
        && $stable(data_out)) else $error("index or data moved");
    a_no_fight: assert property (data_oe |-> output_gate_n)
        else $error("host drives into memory");
    a_float_gap: assert property ($rose(output_gate_n) |-> !data_oe[*2])
        else $error("host drives too soon");
    a_sleep_park: assert property (sleep_ack |-> select_low_n && !data_oe && !req_ready)
        else $error("not parked");
    a_wake_wait: assert property ($fell(sleep_ack) |-> !req_ready)
        else $error("wake too short");
endmodule
bind asr_host_ctrl asr_host_ctrl_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_index(req_index), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .sleep_ack(sleep_ack), .word_index(word_index), .select_low_n(select_low_n),
    .select_high(select_high), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module testbench
    import asr_pkg::*;
();
    logic clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic sleep_req = 1'b0, slow = 1'b0;
    logic [INDEX_W-1:0] req_index = 13'h0000;
    logic [DATA_W-1:0]  req_wdata = 9'h000;
    logic req_ready, rsp_valid, sleep_ack, select_low_n, select_high;
    logic output_gate_n, write_strobe_n, data_oe, clash;
    logic [DATA_W-1:0]  rsp_rdata, data_in, data_out;
    logic [INDEX_W-1:0] word_index;
    int err_count = 0;
    int samples_checked = 0;
    always #10 clk_sys = ~clk_sys; // 50 MHz
    asr_host_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_index(req_index),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sleep_req(sleep_req), .sleep_ack(sleep_ack), .word_index(word_index),
        .select_low_n(select_low_n), .select_high(select_high),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    asr_sram_model u_mem (.word_index(word_index), .select_low_n(select_low_n),
        .select_high(select_high), .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n), .host_data(data_out), .host_oe(data_oe),
        .slow(slow), .pin_level(data_in), .clash(clash));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Bounded wait at falling edges: 0 ready, 1 answer, 2 park ack
    // Flag picked by number, so no reference argument is needed
    task automatic wait_flag(input int sel, output int n);
        logic f;
        n = 0;
        f = 1'b0;
        while (f !== 1'b1) begin
            if (n >= 40) begin
                err_count++;
                $display("FAIL %0t wait ran out", $time);
                close_out();
            end
            @(negedge clk_sys);
            n++;
            f = (sel == 0) ? req_ready : ((sel == 1) ? rsp_valid : sleep_ack);
        end
    endtask
    // One request, held until taken; returns at the taking edge
    task automatic access(input logic w, input logic [INDEX_W-1:0] i,
                          input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_index <= i;
        req_wdata <= d;
        wait_flag(0, n);
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask
    task automatic rd(input logic [INDEX_W-1:0] i, input logic [DATA_W-1:0] e);
        int n;
        access(1'b0, i, 9'h000);
        wait_flag(1, n);
        chk(16'(n), 16'h0005);
        chk(16'(rsp_rdata), 16'(e));
    endtask
    // Any fight on the shared pins is a mismatch
    always @(posedge clash) begin
        chk(16'h0001, 16'h0000);
    end
    // Deselected and quiet in reset
    task automatic sc_reset();
        logic [4:0] pins;
        @(negedge clk_sys);
        pins = {select_low_n, select_high, output_gate_n, write_strobe_n, data_oe};
        chk(16'(pins), 16'h0016);
    endtask
    // Both ends of the index, back-to-back, fast part
    task automatic sc_edges();
        access(1'b1, 13'h0000, 9'h1FF);
        access(1'b1, 13'h1FFF, 9'h000);
        access(1'b1, 13'h0001, 9'h155);
        rd(13'h0000, 9'h1FF);
        rd(13'h1FFF, 9'h000);
        rd(13'h0001, 9'h155);
    endtask
    // Slow part, reads and writes interleaved, overwrite
    task automatic sc_slow();
        slow = 1'b1;
        access(1'b1, 13'h0000, 9'h0AA);
        rd(13'h0000, 9'h0AA);
        access(1'b1, 13'h0002, 9'h123);
        rd(13'h1FFF, 9'h000);
        rd(13'h0002, 9'h123);
    endtask
    // Retention park, refusal while parked, contents kept
    task automatic sc_sleep();
        int n;
        @(posedge clk_sys);
        sleep_req <= 1'b1;
        wait_flag(2, n);
        repeat (3) @(negedge clk_sys);
        chk(16'({select_low_n, select_high, data_oe, req_ready}), 16'h0008);
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        rd(13'h0000, 9'h0AA);
    endtask
    initial begin
        sc_reset();
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        sc_edges();
        sc_slow();
        sc_sleep();
        close_out();
    end
endmodule
`default_nettype wire
